// File: rtl/io_word_pkg.sv
/*
  Shared constants and word layout for the input word collector and
  output word distributor. Assumes an 18-bit machine word whose bit 0
  is the most significant and sits at the top of the packed vector.
*/
package io_word_pkg;

  // Word geometry
  localparam int WORD_W = 18;
  localparam int HALF_W = 9;

  // Channel counts, standard collector and expansion groups
  localparam int STD_CHANNELS     = 7;
  localparam int EXP_FIRST_CHANS  = 6;
  localparam int EXP_GROUP_CHANS  = 7;
  localparam int EXP_SLICES_GROUP = 18;

  // Channel slots, zero based (channel 1 is slot 0)
  localparam int CH_READER  = 0;
  localparam int CH_STATUS  = 1;
  localparam int CH_FREE_LO = 2;
  localparam int CH_FREE_N  = 3;
  localparam int CH_TTY     = 5;
  localparam int CH_STEP    = 6;
  localparam int CH_EXP_HUB = 2;

  // Fixed field widths inside the dedicated channels
  localparam int STATUS_BITS   = 9;
  localparam int TTY_OPEN_BITS = 10;
  localparam int TTY_CHAR_BITS = 8;
  localparam int STEP_OPEN     = 12;
  localparam int STEP_BITS     = 6;

  // Transfer code of the status read instruction, octal 0314
  localparam logic [11:0] STATUS_READ_CODE = 12'h0CC;

  // Reset values and buffering
  localparam logic [WORD_W-1:0] ACC_RESET = 18'h00000;
  localparam int FIFO_DEPTH = 4;

  // One machine word: upper half is bits 0-8, lower half bits 9-17
  typedef struct packed {
    logic [HALF_W-1:0] upper;
    logic [HALF_W-1:0] lower;
  } word_s;

  localparam word_s WORD_ZERO = '{upper: 9'h000, lower: 9'h000};

endpackage : io_word_pkg

// File: rtl/word_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides. Assumes one
  clock and that DEPTH is a power of two of at least two.
*/
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  wire              push;
  wire              pop;
  wire              ptr_wrap;

  // Full when pointers differ only in the wrap bit
  assign ptr_wrap  = wr_ptr_q[AW] != rd_ptr_q[AW];
  assign in_ready  = !(ptr_wrap && wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign out_valid = wr_ptr_q != rd_ptr_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

  // Storage has no reset; only pointers define content
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + (AW+1)'(push);
      rd_ptr_q <= rd_ptr_q + (AW+1)'(pop);
    end
  end

endmodule // word_fifo

// File: rtl/io_word_collector_distributor.sv
/*
  Input word collector and output word distributor around the main
  accumulator. Peripheral pins (data and transfer pulses) come from
  outside the clock domain; processor controls are on the same clock.
  A collected word waits in a four-word FIFO until the processor side
  accepts it into the accumulator.
*/
// Notes on behaviour
// - Channel word: upper bits 0-8, lower 9-17
// - Each bit ANDed with its channel enable
// - One transfer pulse gates the whole word
// - Channels ORed per bit, setting accumulator bits
// - Channel 1 carries the tape reader word
// - Channel 2 first nine bits: status
// - Channels 3 to 5 free for peripherals
// - Channel 6 last eight bits: teleprinter
// - Channel 7 last six bits: step counter
// - First expansion rides one channel, adds six
// - Each further group adds seven channels
// - Eighteen buffered accumulator output lines
// - Outputs static; peripheral strobes them itself
// - Stored 0 at minus level, 1 at ground
`timescale 1ns/1ps
module io_word_collector_distributor #(
  parameter int EXP_GROUPS = 0,
  parameter int FIFO_DEPTH = io_word_pkg::FIFO_DEPTH,
  localparam int EXP_CH = (EXP_GROUPS == 0) ? 0 :
    io_word_pkg::EXP_FIRST_CHANS +
    io_word_pkg::EXP_GROUP_CHANS * (EXP_GROUPS - 1),
  localparam int EXP_PORTS = (EXP_CH == 0) ? 1 : EXP_CH
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire io_word_pkg::word_s         tape_reader_buffer,
  input  wire logic [8:0]                 io_status_read,
  input  wire logic [8:0]                 status_lower_aux,
  input  wire io_word_pkg::word_s         free_word [3],
  input  wire logic [9:0]                 tty_open_bits,
  input  wire logic [7:0]                 tty_char,
  input  wire logic [11:0]                step_open_bits,
  input  wire logic [5:0]                 multiply_step_counter,
  input  wire io_word_pkg::word_s         exp_word [EXP_PORTS],
  input  wire logic [6:0]                 io_transfer_pulse,
  input  wire logic [EXP_PORTS-1:0]       exp_transfer_pulse,
  output logic                            collector_ready,
  output logic                            collect_overrun_q,
  input  wire logic                       acc_accept,
  output logic                            word_pending,
  input  wire logic                       acc_clear,
  input  wire logic                       acc_load,
  input  wire io_word_pkg::word_s         acc_load_data,
  output io_word_pkg::word_s              main_accumulator,
  output logic [17:0]                     buffered_accumulator_out
);

  localparam int N_CH = io_word_pkg::STD_CHANNELS + EXP_CH;

  // Raw channel words and pulses before synchronising
  io_word_pkg::word_s ch_raw [N_CH];
  logic [N_CH-1:0]    pulse_raw;

  // Fixed channel use of the standard collector
  assign ch_raw[io_word_pkg::CH_READER] = tape_reader_buffer;
  assign ch_raw[io_word_pkg::CH_STATUS] =
    '{upper: io_status_read, lower: status_lower_aux};
  assign ch_raw[io_word_pkg::CH_TTY] =
    io_word_pkg::word_s'({tty_open_bits, tty_char});
  assign ch_raw[io_word_pkg::CH_STEP] =
    io_word_pkg::word_s'({step_open_bits, multiply_step_counter});
  assign pulse_raw[io_word_pkg::STD_CHANNELS-1:0] = io_transfer_pulse;

  // Open channels 3, 4 and 5 pass straight through
  genvar gf;
  generate
    for (gf = 0; gf < io_word_pkg::CH_FREE_N; gf++) begin : g_free
      assign ch_raw[io_word_pkg::CH_FREE_LO + gf] = free_word[gf];
    end
  endgenerate

  // Expansion channels follow the standard seven
  genvar ge;
  generate
    for (ge = 0; ge < EXP_CH; ge++) begin : g_exp
      assign ch_raw[io_word_pkg::STD_CHANNELS + ge] = exp_word[ge];
      assign pulse_raw[io_word_pkg::STD_CHANNELS + ge] =
        exp_transfer_pulse[ge];
    end
  endgenerate

  // Two-stage synchronisers; stage one feeds only stage two
  io_word_pkg::word_s ch_s1_q [N_CH];
  io_word_pkg::word_s ch_s2_q [N_CH];
  logic [N_CH-1:0]    pulse_s1_q;
  logic [N_CH-1:0]    pulse_s2_q;
  logic [N_CH-1:0]    pulse_s3_q;

  // Data and pulse cross with equal delay, so a pulse held over a
  // few clocks sees its data already settled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N_CH; i++) begin
        ch_s1_q[i] <= io_word_pkg::WORD_ZERO;
        ch_s2_q[i] <= io_word_pkg::WORD_ZERO;
      end
    end else begin
      for (int i = 0; i < N_CH; i++) begin
        ch_s1_q[i] <= ch_raw[i];
        ch_s2_q[i] <= ch_s1_q[i];
      end
    end
  end

  // Pulse synchroniser plus a third stage for edge detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse_s1_q <= '0;
      pulse_s2_q <= '0;
      pulse_s3_q <= '0;
    end else begin
      pulse_s1_q <= pulse_raw;
      pulse_s2_q <= pulse_s1_q;
      pulse_s3_q <= pulse_s2_q;
    end
  end

  // Per channel bit gates: data AND shared channel enable
  logic [17:0] gated [N_CH];
  genvar gc;
  generate
    for (gc = 0; gc < N_CH; gc++) begin : g_gate
      assign gated[gc] = ch_s2_q[gc] & {18{pulse_s2_q[gc]}};
    end
  endgenerate

  // Expansion merges onto the slot of channel 3 as one wired input
  logic [17:0] exp_merged;
  always_comb begin
    exp_merged = 18'h00000;
    for (int i = io_word_pkg::STD_CHANNELS; i < N_CH; i++) begin
      exp_merged = exp_merged | gated[i];
    end
  end

  // Bitwise OR of all standard slots plus the expansion
  logic [17:0] merged_bits;
  always_comb begin
    merged_bits = 18'h00000;
    for (int i = 0; i < io_word_pkg::STD_CHANNELS; i++) begin
      if (i == io_word_pkg::CH_EXP_HUB) begin
        merged_bits = merged_bits | gated[i] | exp_merged;
      end else begin
        merged_bits = merged_bits | gated[i];
      end
    end
  end

  // A new transfer starts on any rising pulse edge
  wire                 pulse_rise = |(pulse_s2_q & ~pulse_s3_q);
  io_word_pkg::word_s  merged_word;
  io_word_pkg::word_s  fifo_word;
  wire                 fifo_in_ready;
  wire                 fifo_valid;
  wire                 take_word;

  assign merged_word     = io_word_pkg::word_s'(merged_bits);
  assign collector_ready = fifo_in_ready;
  assign word_pending    = fifo_valid;

  // Load has priority; a word waits rather than being mixed into it
  assign take_word = fifo_valid && acc_accept && !acc_load;

  word_fifo #(
    .WIDTH (io_word_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_data   (merged_word),
    .in_valid  (pulse_rise),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_word),
    .out_valid (fifo_valid),
    .out_ready (take_word)
  );

  // Sticky overrun: a transfer arrived while the FIFO was full.
  // Cleared only by reset, as pins give no way to acknowledge it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      collect_overrun_q <= 1'b0;
    end else if (pulse_rise && !fifo_in_ready) begin
      collect_overrun_q <= 1'b1;
    end
  end

  // Accumulator next value: clear and set in one cycle, set wins
  io_word_pkg::word_s acc_q;
  io_word_pkg::word_s acc_d;
  wire         [17:0] acc_base;

  assign acc_base = acc_clear ? 18'h00000 : acc_q;
  assign acc_d = acc_load  ? acc_load_data :
                 take_word ? io_word_pkg::word_s'(acc_base | fifo_word) :
                 io_word_pkg::word_s'(acc_base);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_q <= io_word_pkg::ACC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Static levels straight from the accumulator flops; 1 = ground,
  // 0 = negative level at the connector driver
  assign main_accumulator         = acc_q;
  assign buffered_accumulator_out = acc_q;

  // Checks
  logic [N_CH-1:0] only_mask;
  assign only_mask = pulse_s2_q;

  sequence s_rise_taken;
    pulse_rise && fifo_in_ready;
  endsequence

  sequence s_word_queued;
    ##1 fifo_valid;
  endsequence

  property p_queue_on_rise;
    @(posedge clock) disable iff (rst)
      s_rise_taken |-> s_word_queued;
  endproperty

  a_rise_queues_word: assert property (p_queue_on_rise)
    else $error("rising transfer pulse did not queue a word");

  a_no_enable_zero: assert property (
    @(posedge clock) disable iff (rst)
      (pulse_s2_q == '0) |-> (merged_bits == 18'h00000))
    else $error("merged word nonzero without any enable");

  a_merge_sets_bits: assert property (
    @(posedge clock) disable iff (rst)
      (take_word && !acc_clear) |=>
        ((acc_q & $past(fifo_word)) == $past(fifo_word)) &&
        ((acc_q & $past(acc_q)) == $past(acc_q)))
    else $error("accepted word did not set accumulator bits");

  a_set_beats_clear: assert property (
    @(posedge clock) disable iff (rst)
      (take_word && acc_clear) |=> (acc_q == $past(fifo_word)))
    else $error("clear in accept cycle lost collected bits");

  a_reader_channel: assert property (
    @(posedge clock) disable iff (rst)
      (only_mask == N_CH'(1) << io_word_pkg::CH_READER) |->
        (merged_bits == ch_s2_q[io_word_pkg::CH_READER]))
    else $error("reader channel word not passed whole");

  a_status_upper: assert property (
    @(posedge clock) disable iff (rst)
      (only_mask == N_CH'(1) << io_word_pkg::CH_STATUS) |->
        (merged_word.upper ==
         ch_s2_q[io_word_pkg::CH_STATUS].upper))
    else $error("status bits not in upper half");

  a_status_lower: assert property (
    @(posedge clock) disable iff (rst)
      (only_mask == N_CH'(1) << io_word_pkg::CH_STATUS) |->
        (merged_word.lower ==
         ch_s2_q[io_word_pkg::CH_STATUS].lower))
    else $error("spare status inputs not in lower half");

  a_free_channel: assert property (
    @(posedge clock) disable iff (rst)
      (only_mask == N_CH'(1) << (io_word_pkg::CH_FREE_LO + 1)) |->
        (merged_bits ==
         ch_s2_q[io_word_pkg::CH_FREE_LO + 1]))
    else $error("open channel word altered");

  a_hub_channel: assert property (
    @(posedge clock) disable iff (rst)
      (only_mask == N_CH'(1) << io_word_pkg::CH_EXP_HUB) |->
        (merged_bits == ch_s2_q[io_word_pkg::CH_EXP_HUB]))
    else $error("channel 3 pins lost on the expansion slot");

  a_tty_field: assert property (
    @(posedge clock) disable iff (rst)
      (only_mask == N_CH'(1) << io_word_pkg::CH_TTY) |=>
        ($past(merged_bits[7:0]) == $past(tty_char, 3)))
    else $error("teleprinter character not in last eight bits");

  a_step_field: assert property (
    @(posedge clock) disable iff (rst)
      (only_mask == N_CH'(1) << io_word_pkg::CH_STEP) |->
        (merged_bits[5:0] ==
         ch_s2_q[io_word_pkg::CH_STEP][5:0]))
    else $error("step counter not in last six bits");

  // Expansion channels reach the merge through the channel 3 slot
  generate
    if (EXP_CH > 0) begin : g_exp_chk
      a_exp_channel: assert property (
        @(posedge clock) disable iff (rst)
          (only_mask == N_CH'(1) << io_word_pkg::STD_CHANNELS) |->
            (merged_bits == ch_s2_q[io_word_pkg::STD_CHANNELS]))
        else $error("expansion channel word not merged");
    end
  endgenerate

  a_output_static: assert property (
    @(posedge clock) disable iff (rst)
      (!acc_load && !acc_clear && !take_word) |=>
        $stable(buffered_accumulator_out))
    else $error("output levels moved without a cause");

  a_load_drives_out: assert property (
    @(posedge clock) disable iff (rst)
      acc_load |=>
        (buffered_accumulator_out == $past(acc_load_data)))
    else $error("loaded value not presented on outputs");

  // Accumulator control and queue checks
  a_clear_zeros: assert property (
    @(posedge clock) disable iff (rst)
      (acc_clear && !acc_load && !take_word) |=>
        (acc_q == 18'h00000))
    else $error("clear alone left accumulator bits set");

  a_load_defers: assert property (
    @(posedge clock) disable iff (rst)
      (fifo_valid && acc_accept && acc_load) |=> fifo_valid)
    else $error("word lost while load had priority");

  a_overrun_flag: assert property (
    @(posedge clock) disable iff (rst)
      (pulse_rise && !fifo_in_ready) |=> collect_overrun_q)
    else $error("dropped transfer not flagged");

  a_overrun_sticky: assert property (
    @(posedge clock) disable iff (rst)
      collect_overrun_q |=> collect_overrun_q)
    else $error("overrun flag cleared without reset");

endmodule // io_word_collector_distributor

// File: dv/periph_model.sv
/*
  Behavioural peripheral controllers on the far side of the collector
  and distributor: seven channel data words, their transfer pulses,
  and a register that strobes the buffered accumulator levels.
  Assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/1ps
module periph_model (
  input  wire logic               clock,
  input  wire logic [17:0]        acc_levels,
  output io_word_pkg::word_s      tape_word,
  output logic [8:0]              status_hi,
  output logic [8:0]              status_lo,
  output io_word_pkg::word_s      free_w [3],
  output logic [9:0]              tty_open,
  output logic [7:0]              tty_chr,
  output logic [11:0]             step_open,
  output logic [5:0]              step_cnt,
  output logic [6:0]              pulse
);
  logic [17:0] ch_data [7];

  // Channel slots onto the pins; bit 17 is machine bit 0
  assign tape_word              = io_word_pkg::word_s'(ch_data[0]);
  assign {status_hi, status_lo} = ch_data[1];
  assign free_w[0]              = io_word_pkg::word_s'(ch_data[2]);
  assign free_w[1]              = io_word_pkg::word_s'(ch_data[3]);
  assign free_w[2]              = io_word_pkg::word_s'(ch_data[4]);
  assign {tty_open, tty_chr}    = ch_data[5];
  assign {step_open, step_cnt}  = ch_data[6];

  // Idle lines carry junk, never zero, so weak gating shows up
  initial begin
    pulse = 7'h00;
    for (int i = 0; i < 7; i++) ch_data[i] = 18'h2AAAA;
  end

  // One word on one channel; other channels show its inverse
  task automatic send(input int ch, input logic [17:0] w);
    @(posedge clock);
    #1;
    for (int i = 0; i < 7; i++) ch_data[i] = (i == ch) ? w : ~w;
    pulse = 7'h01 << ch;
    repeat (3) @(posedge clock);
    #1;
    pulse = 7'h00;
    for (int i = 0; i < 7; i++) ch_data[i] = ~w;
    repeat (3) @(posedge clock);
  endtask

  // Strobe the static levels into our own register on a pulse
  task automatic capture(output logic [17:0] v);
    @(posedge clock);
    v = acc_levels;
  endtask
endmodule // periph_model

// File: dv/tb.sv
/*
  Self-checking bench for the collector and distributor. Assumes the
  peripheral model above and the first expansion group fitted, whose
  six channels the bench drives itself.
*/
`timescale 1ns/1ps
module tb;
  logic               clock;
  logic               rst;
  io_word_pkg::word_s tape_word;
  logic [8:0]         status_hi;
  logic [8:0]         status_lo;
  io_word_pkg::word_s free_w [3];
  logic [9:0]         tty_open;
  logic [7:0]         tty_chr;
  logic [11:0]        step_open;
  logic [5:0]         step_cnt;
  logic [6:0]         pulse;
  io_word_pkg::word_s exp_w [6];
  logic [5:0]         exp_pulse;
  logic               collector_ready;
  logic               collect_overrun_q;
  logic               acc_accept;
  logic               word_pending;
  logic               acc_clear;
  logic               acc_load;
  io_word_pkg::word_s load_d;
  io_word_pkg::word_s main_accumulator;
  logic [17:0]        acc_out;
  logic [17:0]        acc_v;
  int                 n_errors;
  int                 checked;

  assign acc_v = main_accumulator;

  io_word_collector_distributor #(.EXP_GROUPS(1)) uut (
    .clock(clock), .rst(rst), .tape_reader_buffer(tape_word),
    .io_status_read(status_hi), .status_lower_aux(status_lo),
    .free_word(free_w), .tty_open_bits(tty_open), .tty_char(tty_chr),
    .step_open_bits(step_open), .multiply_step_counter(step_cnt),
    .exp_word(exp_w), .io_transfer_pulse(pulse),
    .exp_transfer_pulse(exp_pulse), .collector_ready(collector_ready),
    .collect_overrun_q(collect_overrun_q), .acc_accept(acc_accept),
    .word_pending(word_pending), .acc_clear(acc_clear),
    .acc_load(acc_load), .acc_load_data(load_d),
    .main_accumulator(main_accumulator),
    .buffered_accumulator_out(acc_out)
  );

  periph_model pm (
    .clock(clock), .acc_levels(acc_out), .tape_word(tape_word),
    .status_hi(status_hi), .status_lo(status_lo), .free_w(free_w),
    .tty_open(tty_open), .tty_chr(tty_chr), .step_open(step_open),
    .step_cnt(step_cnt), .pulse(pulse)
  );

  // Free-running 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Compare and count; one line per mismatch
  task automatic check(input logic [17:0] exp, input logic [17:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      n_errors++;
    end
  endtask

  // Verdict and end of run, also reached from a stuck wait
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One-cycle processor control, released after its edge
  task automatic acc_op(input logic clr, input logic ld, input logic acp,
                        input logic [17:0] d);
    @(posedge clock);
    #1;
    acc_clear  = clr;
    acc_load   = ld;
    acc_accept = acp;
    load_d     = io_word_pkg::word_s'(d);
    @(posedge clock);
    #1;
    acc_clear  = 1'b0;
    acc_load   = 1'b0;
    acc_accept = 1'b0;
  endtask

  // Bounded wait for a queued word
  task automatic wait_pending();
    for (int k = 0; k < 20 && word_pending !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    if (word_pending !== 1'b1) begin
      $display("wrong value at %0t: expected 1 got %h", $time, word_pending);
      n_errors++;
      finish_test();
    end
  endtask

  // Idle state straight after reset
  task automatic t_reset();
    check(18'h00000, acc_v);
    check(18'h00001, {17'h00000, collector_ready});
    check(18'h00000, {16'h0000, word_pending, collect_overrun_q});
  endtask

  // Every standard channel delivers its own word, gated from the others
  task automatic t_channels();
    logic [17:0] pat [7];
    pat = '{18'h3FE01, 18'h1FF00, 18'h2D2B4, 18'h1234B,
            18'h0C3F0, 18'h000A5, 18'h0003C};
    for (int ch = 0; ch < 7; ch++) begin
      acc_op(1'b1, 1'b0, 1'b0, 18'h00000);
      pm.send(ch, pat[ch]);
      wait_pending();
      acc_op(1'b0, 1'b0, 1'b1, 18'h00000);
      check(pat[ch], acc_v);
      check(pat[ch], acc_out);
      check(18'h00000, {17'h00000, word_pending});
    end
  endtask

  // Collected bits only set; loaded ones stay
  task automatic t_merge();
    acc_op(1'b0, 1'b1, 1'b0, 18'h20401);
    pm.send(2, 18'h01230);
    wait_pending();
    acc_op(1'b0, 1'b0, 1'b1, 18'h00000);
    check(18'h21631, acc_v);
  endtask

  // Load beats accept; clear with accept leaves just the word
  task automatic t_priority();
    pm.send(0, 18'h00F0F);
    wait_pending();
    acc_op(1'b0, 1'b1, 1'b1, 18'h30000);
    check(18'h30000, acc_v);
    check(18'h00001, {17'h00000, word_pending});
    acc_op(1'b1, 1'b0, 1'b1, 18'h00000);
    check(18'h00F0F, acc_v);
    check(18'h00000, {17'h00000, word_pending});
  endtask

  // Fill the queue, overrun it, then drain back to back
  task automatic t_fifo();
    acc_op(1'b1, 1'b0, 1'b0, 18'h00000);
    for (int i = 0; i < 4; i++) pm.send(i + 3, 18'h00003 << (4 * i));
    check(18'h00000, {17'h00000, collector_ready});
    pm.send(1, 18'h20000);
    check(18'h00001, {17'h00000, collect_overrun_q});
    @(posedge clock);
    #1;
    acc_accept = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    acc_accept = 1'b0;
    check(18'h03333, acc_v);
    check(18'h00002, {16'h0000, collector_ready, word_pending});
  endtask

  // First expansion group: six more channels through channel 3's slot
  task automatic t_expansion();
    for (int e = 0; e < 6; e++) begin
      acc_op(1'b1, 1'b0, 1'b0, 18'h00000);
      @(posedge clock);
      #1;
      exp_w[e]  = io_word_pkg::word_s'(18'h00041 << e);
      exp_pulse = 6'h01 << e;
      repeat (3) @(posedge clock);
      #1;
      exp_pulse = 6'h00;
      repeat (3) @(posedge clock);
      wait_pending();
      acc_op(1'b0, 1'b0, 1'b1, 18'h00000);
      check(18'h00041 << e, acc_v);
    end
  endtask

  // Peripheral strobes the static levels; 1 means ground
  task automatic t_outputs();
    logic [17:0] v;
    acc_op(1'b0, 1'b1, 1'b0, 18'h2A5C3);
    pm.capture(v);
    check(18'h2A5C3, v);
    check(18'h2A5C3, acc_out);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    n_errors   = 0;
    checked    = 0;
    rst        = 1'b1;
    acc_accept = 1'b0;
    acc_clear  = 1'b0;
    acc_load   = 1'b0;
    load_d     = io_word_pkg::WORD_ZERO;
    exp_pulse  = 6'h00;
    for (int e = 0; e < 6; e++) begin
      exp_w[e] = io_word_pkg::WORD_ZERO;
    end
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clock);
    t_reset();
    t_channels();
    t_merge();
    t_priority();
    t_fifo();
    t_expansion();
    t_outputs();
    finish_test();
  end
endmodule // tb
